// ==== hdl/vsd_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module vsd_top
  import vsd_pkg::*;
#(
  parameter int HS_WIN = HS_WIN_CYC,
  parameter int VS_WIN = VS_WIN_CYC,
  parameter int LK_WIN = LINK_WIN_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSYNC_IN,
  input wire logic GREEN_SYNC_IN,
  input wire logic VSYNC_IN,
  input wire logic SEP_VSYNC_IN,
  input wire logic LINK_CLK_IN,
  input wire logic COAST_IN,
  input wire logic KEYS_LOADED_IN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic IRQ,
  output logic ACTIVE_IF,
  output logic SEEK_MODE,
  output logic HS_SRC,
  output logic VS_SRC,
  output logic PLL_HSYNC,
  output logic SEL_VSYNC
);
  logic hs_act;
  logic grn_act;
  logic vs_act;
  logic lk_act;
  logic hs_pol;
  logic vs_pol;
  logic cst_pol;
  logic [7:0] cfg_if_q;
  logic [7:0] cfg_sync_q;
  logic [7:0] cfg_coast_q;
  logic [7:0] irq_en_q;
  logic [EV_NUM-1:0] irq_stat_q;
  logic [EV_NUM-1:0] irq_stat_d;
  logic [EV_NUM-1:0] irq_clr;
  logic [EV_NUM-1:0] ev;
  logic analog_det;
  logic digital_det;
  vsd_if_t if_d;
  vsd_if_t if_q;
  logic hsrc_d;
  logic vsrc_d;
  logic [3:0] act_prev_q;
  logic keys_prev_q;
  logic [7:0] act_stat;
  logic [7:0] src_stat;
  logic [7:0] rd_mux;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  vsd_act_det #(.WIN(HS_WIN)) u_hs_act (
    .clk(CLK),
    .rst(RST),
    .sig(HSYNC_IN),
    .active(hs_act)
  );

  vsd_act_det #(.WIN(HS_WIN)) u_grn_act (
    .clk(CLK),
    .rst(RST),
    .sig(GREEN_SYNC_IN),
    .active(grn_act)
  );

  vsd_act_det #(.WIN(VS_WIN)) u_vs_act (
    .clk(CLK),
    .rst(RST),
    .sig(VSYNC_IN),
    .active(vs_act)
  );

  vsd_act_det #(.WIN(LK_WIN)) u_lk_act (
    .clk(CLK),
    .rst(RST),
    .sig(LINK_CLK_IN),
    .active(lk_act)
  );

  vsd_pol_det u_hs_pol (
    .clk(CLK),
    .rst(RST),
    .sig(HSYNC_IN),
    .high_pol(hs_pol)
  );

  vsd_pol_det u_vs_pol (
    .clk(CLK),
    .rst(RST),
    .sig(SEL_VSYNC),
    .high_pol(vs_pol)
  );

  vsd_pol_det u_cst_pol (
    .clk(CLK),
    .rst(RST),
    .sig(COAST_IN),
    .high_pol(cst_pol)
  );

  // configuration; status addresses are not decoded here so writes drop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_if_q <= CFG_IF_RST;
      cfg_sync_q <= CFG_SYNC_RST;
      cfg_coast_q <= CFG_COAST_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (WR) begin
      case (ADDR)
        CFG_IF_ADDR: cfg_if_q <= WDATA;
        CFG_SYNC_ADDR: cfg_sync_q <= WDATA;
        CFG_COAST_ADDR: cfg_coast_q <= WDATA;
        IRQ_EN_ADDR: irq_en_q <= WDATA;
        default: ;
      endcase
    end
  end

  assign analog_det = hs_act | grn_act | vs_act;
  assign digital_det = lk_act;

  always_comb begin
    if (cfg_if_q[IF_OVR_BIT]) begin
      if_d = cfg_if_q[IF_PRIO_BIT] ? VSD_DIGITAL : VSD_ANALOG;
    end else if (!analog_det && !digital_det) begin
      if_d = VSD_SEEK;
    end else begin
      if_d = vsd_pick(analog_det, digital_det, cfg_if_q[IF_PRIO_BIT], 1'b0)
             ? VSD_DIGITAL : VSD_ANALOG;
    end
  end

  assign hsrc_d = vsd_pick(hs_act, grn_act, cfg_sync_q[HS_PRIO_BIT],
                           cfg_sync_q[HS_OVR_BIT]);
  assign vsrc_d = cfg_sync_q[VS_OVR_BIT] ? cfg_sync_q[VS_SEL_BIT] : vs_act;

  // in seek mode the interface bit keeps its last choice
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      if_q <= VSD_SEEK;
      ACTIVE_IF <= 1'b0;
      SEEK_MODE <= 1'b1;
    end else begin
      if_q <= if_d;
      SEEK_MODE <= (if_d == VSD_SEEK);
      case (if_d)
        VSD_ANALOG: ACTIVE_IF <= 1'b0;
        VSD_DIGITAL: ACTIVE_IF <= 1'b1;
        VSD_SEEK: ACTIVE_IF <= ACTIVE_IF;
        default: ACTIVE_IF <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HS_SRC <= 1'b0;
      VS_SRC <= 1'b0;
    end else begin
      HS_SRC <= hsrc_d;
      VS_SRC <= vsrc_d;
    end
  end

  // one register stage on the sync path; a fixed 40 ns delay the PLL absorbs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PLL_HSYNC <= 1'b0;
      SEL_VSYNC <= 1'b0;
    end else begin
      PLL_HSYNC <= HS_SRC ? GREEN_SYNC_IN : HSYNC_IN;
      SEL_VSYNC <= VS_SRC ? SEP_VSYNC_IN : VSYNC_IN;
    end
  end

  // live status, rebuilt every cycle from the detectors, the selected sources and the key input
  always_comb begin
    act_stat = 8'h00;
    act_stat[HS_DET_BIT] = hs_act;
    act_stat[GRN_DET_BIT] = grn_act;
    act_stat[VS_DET_BIT] = vs_act;
    act_stat[LINK_DET_BIT] = lk_act;
    act_stat[ACT_IF_BIT] = ACTIVE_IF;
    src_stat = 8'h00;
    src_stat[HSRC_BIT] = HS_SRC;
    src_stat[HS_POL_BIT] = hs_pol;
    src_stat[AVS_BIT] = VS_SRC;
    src_stat[VS_POL_BIT] = ~vs_pol;
    src_stat[CST_POL_BIT] = cfg_coast_q[COAST_EN_BIT] & cst_pol;
    src_stat[KEY_BIT] = KEYS_LOADED_IN;
  end

  always_comb begin
    case (ADDR)
      CFG_IF_ADDR: rd_mux = cfg_if_q;
      CFG_SYNC_ADDR: rd_mux = cfg_sync_q;
      CFG_COAST_ADDR: rd_mux = cfg_coast_q;
      ACT_STAT_ADDR: rd_mux = act_stat;
      SRC_STAT_ADDR: rd_mux = src_stat;
      IRQ_STAT_ADDR: rd_mux = {{(8 - EV_NUM){1'b0}}, irq_stat_q};
      IRQ_EN_ADDR: rd_mux = irq_en_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  // events for the interrupt logic
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      act_prev_q <= 4'h0;
      keys_prev_q <= 1'b0;
    end else begin
      act_prev_q <= {hs_act, grn_act, vs_act, lk_act};
      keys_prev_q <= KEYS_LOADED_IN;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_IF_CHG] = (if_d != if_q) && (if_d != VSD_SEEK);
    ev[EV_HS_CHG] = hsrc_d != HS_SRC;
    ev[EV_ACT_CHG] = act_prev_q != {hs_act, grn_act, vs_act, lk_act};
    ev[EV_SEEK] = (if_d == VSD_SEEK) && (if_q != VSD_SEEK);
    ev[EV_KEYS] = KEYS_LOADED_IN && !keys_prev_q;
  end

  assign irq_clr = (WR && ADDR == IRQ_CLR_ADDR) ? WDATA[EV_NUM-1:0] : '0;
  // a new event wins over a clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | ev;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat_q <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      IRQ <= |(irq_stat_q & irq_en_q[EV_NUM-1:0]);
    end
  end

  // helper: cycles since the horizontal input last changed
  int hs_still;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hs_still <= 0;
    end else if (HSYNC_IN != $past(HSYNC_IN)) begin
      hs_still <= 0;
    end else if (hs_still < HS_WIN + 4) begin
      hs_still <= hs_still + 1;
    end
  end

  chk_if_override: assert property (
    cfg_if_q[IF_OVR_BIT] |=> ACTIVE_IF == $past(cfg_if_q[IF_PRIO_BIT]))
    else $error("interface override not applied");

  chk_if_digital_only: assert property (
    !cfg_if_q[IF_OVR_BIT] && !analog_det && digital_det |=> ACTIVE_IF)
    else $error("digital-only did not select digital");

  chk_if_analog_only: assert property (
    !cfg_if_q[IF_OVR_BIT] && analog_det && !digital_det |=> !ACTIVE_IF && !SEEK_MODE)
    else $error("analog-only did not select analog");

  chk_seek_none: assert property (
    !cfg_if_q[IF_OVR_BIT] && !analog_det && !digital_det
    |=> SEEK_MODE && $stable(ACTIVE_IF))
    else $error("no detection did not enter seek mode");

  chk_hsrc_override: assert property (
    cfg_sync_q[HS_OVR_BIT] |=> HS_SRC == $past(cfg_sync_q[HS_PRIO_BIT]))
    else $error("horizontal override not applied");

  chk_hsrc_pin_only: assert property (
    !cfg_sync_q[HS_OVR_BIT] && hs_act && !grn_act |=> !HS_SRC)
    else $error("lone hsync did not pick hsync pin");

  chk_vsrc_follow: assert property (
    !cfg_sync_q[VS_OVR_BIT] |=> VS_SRC == $past(vs_act))
    else $error("vertical source not following detect");

  chk_pll_source: assert property (
    HS_SRC ##1 HS_SRC |-> PLL_HSYNC == $past(GREEN_SYNC_IN))
    else $error("pll not fed from green sync");

  chk_vsync_source: assert property (
    !VS_SRC |=> SEL_VSYNC == $past(VSYNC_IN))
    else $error("vertical sync not from pin");

  chk_hs_steady: assert property (
    hs_still > HS_WIN + 2 |-> !hs_act)
    else $error("steady hsync flagged as active");

  chk_link_read: assert property (
    RD && ADDR == ACT_STAT_ADDR |=> RDATA[LINK_DET_BIT] == $past(lk_act))
    else $error("link activity misreported");

  chk_irq_sticky: assert property (
    !(WR && ADDR == IRQ_CLR_ADDR) |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q))
    else $error("interrupt status lost without clear");

  chk_vsrc_override: assert property (
    cfg_sync_q[VS_OVR_BIT] |=> VS_SRC == $past(cfg_sync_q[VS_SEL_BIT]))
    else $error("vertical override not applied");

  chk_hsrc_both: assert property (
    !cfg_sync_q[HS_OVR_BIT] && hs_act && grn_act
    |=> HS_SRC == $past(cfg_sync_q[HS_PRIO_BIT]))
    else $error("both horizontal sources ignored priority");

  chk_pll_pin: assert property (
    !HS_SRC |=> PLL_HSYNC == $past(HSYNC_IN))
    else $error("pll not fed from hsync pin");

  chk_sep_source: assert property (
    VS_SRC |=> SEL_VSYNC == $past(SEP_VSYNC_IN))
    else $error("vertical sync not from separator");

  chk_coast_off: assert property (
    RD && ADDR == SRC_STAT_ADDR && !cfg_coast_q[COAST_EN_BIT] |=> !RDATA[CST_POL_BIT])
    else $error("coast polarity shown while coast disabled");

  chk_key_read: assert property (
    RD && ADDR == SRC_STAT_ADDR |=> RDATA[KEY_BIT] == $past(KEYS_LOADED_IN))
    else $error("key flag misreported");

  // an event in the same cycle as its clear must still be latched
  chk_irq_set_wins: assert property (
    |ev |=> (irq_stat_q & $past(ev)) == $past(ev))
    else $error("interrupt event lost");

  cov_seek: cover property (!SEEK_MODE ##1 SEEK_MODE);
  cov_to_digital: cover property (!ACTIVE_IF ##1 ACTIVE_IF);
  cov_green_source: cover property (!HS_SRC ##1 HS_SRC);
  cov_irq: cover property (!IRQ ##1 IRQ);
  cov_sep_source: cover property (!VS_SRC ##1 VS_SRC);
endmodule

// ==== common/vsd_pkg.sv ====
package vsd_pkg;
  localparam logic [7:0] CFG_IF_ADDR = 8'h0f;
  localparam logic [7:0] CFG_SYNC_ADDR = 8'h10;
  localparam logic [7:0] CFG_COAST_ADDR = 8'h11;
  localparam logic [7:0] ACT_STAT_ADDR = 8'h15;
  localparam logic [7:0] SRC_STAT_ADDR = 8'h16;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h20;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h21;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h22;

  localparam int IF_PRIO_BIT = 1;
  localparam int IF_OVR_BIT = 2;
  localparam int VS_SEL_BIT = 0;
  localparam int VS_OVR_BIT = 1;
  localparam int HS_PRIO_BIT = 3;
  localparam int HS_OVR_BIT = 4;
  localparam int COAST_EN_BIT = 3;
  localparam int HS_DET_BIT = 7;
  localparam int GRN_DET_BIT = 6;
  localparam int VS_DET_BIT = 5;
  localparam int LINK_DET_BIT = 4;
  localparam int ACT_IF_BIT = 3;
  localparam int HSRC_BIT = 7;
  localparam int HS_POL_BIT = 6;
  localparam int AVS_BIT = 5;
  localparam int VS_POL_BIT = 4;
  localparam int CST_POL_BIT = 3;
  localparam int KEY_BIT = 2;

  localparam logic [7:0] CFG_IF_RST = 8'h00;
  localparam logic [7:0] CFG_SYNC_RST = 8'h00;
  localparam logic [7:0] CFG_COAST_RST = 8'h0a;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;

  localparam int EV_IF_CHG = 0;
  localparam int EV_HS_CHG = 1;
  localparam int EV_ACT_CHG = 2;
  localparam int EV_SEEK = 3;
  localparam int EV_KEYS = 4;
  localparam int EV_NUM = 5;

  localparam int CLK_PERIOD_NS = 40;
  localparam int HS_WIN_NS = 100000;
  localparam int VS_WIN_NS = 50000000;
  localparam int LINK_WIN_NS = 1000;
  localparam int HS_WIN_CYC = HS_WIN_NS / CLK_PERIOD_NS;
  localparam int VS_WIN_CYC = VS_WIN_NS / CLK_PERIOD_NS;
  localparam int LINK_WIN_CYC = LINK_WIN_NS / CLK_PERIOD_NS;
  localparam int POL_CNT_W = 20;

  typedef enum logic [1:0] {
    VSD_SEEK = 2'b00,
    VSD_ANALOG = 2'b01,
    VSD_DIGITAL = 2'b10
  } vsd_if_t;

  // two-source choice: override, lone source, else priority
  function automatic logic vsd_pick(input logic det_a, input logic det_b,
                                    input logic prio, input logic ovr);
    if (ovr) begin
      return prio;
    end else if (det_a && !det_b) begin
      return 1'b0;
    end else if (!det_a && det_b) begin
      return 1'b1;
    end
    return prio;
  endfunction
endpackage

// ==== hdl/vsd_act_det.sv ====
`timescale 1ns/1ps
module vsd_act_det
  import vsd_pkg::*;
#(
  parameter int WIN = HS_WIN_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sig,
  output logic active
);
  localparam int CW = $clog2(WIN + 1);
  logic sig_q;
  logic [CW-1:0] cnt_q;
  logic edge_seen;
  logic primed_q;

  // only a toggle counts, so a stuck level never reads as activity
  // first sample after reset only loads history: an idle-high pin is no edge
  assign edge_seen = primed_q && (sig ^ sig_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sig_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      sig_q <= sig;
      primed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      active <= 1'b0;
    end else if (edge_seen) begin
      cnt_q <= '0;
      active <= 1'b1;
    end else if (cnt_q != CW'(WIN - 1)) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      active <= 1'b0;
    end
  end
endmodule

// ==== hdl/vsd_pol_det.sv ====
`timescale 1ns/1ps
module vsd_pol_det
  import vsd_pkg::*;
#(
  parameter int CW = POL_CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sig,
  output logic high_pol
);
  logic sig_q;
  logic [CW-1:0] hi_q;
  logic [CW-1:0] lo_q;

  // the sync pulse is the shorter phase; counters saturate on long gaps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sig_q <= 1'b0;
      hi_q <= '0;
      lo_q <= '0;
      high_pol <= 1'b0;
    end else begin
      sig_q <= sig;
      if (sig && !sig_q) begin
        high_pol <= hi_q < lo_q;
        hi_q <= '0;
        lo_q <= '0;
      end else if (sig) begin
        if (hi_q != '1) begin
          hi_q <= hi_q + 1'b1;
        end
      end else if (lo_q != '1) begin
        lo_q <= lo_q + 1'b1;
      end
    end
  end
endmodule

// ==== verif/vsd_src_model.sv ====
`timescale 1ns/1ps
module vsd_src_model (
  input wire logic clk,
  input wire logic en_hs,
  input wire logic en_grn,
  input wire logic en_vs,
  input wire logic en_lk,
  input wire logic hs_hi,
  output logic hs,
  output logic grn,
  output logic vs,
  output logic sep,
  output logic lk,
  output logic coast
);
  logic [4:0] cnt_q = 5'h00;
  // periods stay well inside the shortened activity windows of the bench
  always_ff @(posedge clk) begin
    cnt_q <= cnt_q + 5'h01;
    // idle line sits at its inactive level: steady, so no activity
    hs <= en_hs ? ((cnt_q[2:0] < 3'h2) ~^ hs_hi) : !hs_hi;
    grn <= en_grn & (cnt_q[2:0] == 3'h3);
    vs <= !(en_vs & (cnt_q < 5'h03));
    // separator pulse offset from the pin so the two sources differ
    sep <= !(en_vs & (cnt_q >= 5'h08) & (cnt_q < 5'h0b));
    // link clock stands still when the digital source is off
    lk <= en_lk & cnt_q[0];
    coast <= cnt_q < 5'h02;
  end
endmodule

// ==== verif/tb_video_source_detect_select.sv ====
`timescale 1ns/1ps
module tb_video_source_detect_select;
  import vsd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_hs = 1'b0, en_grn = 1'b0, en_vs = 1'b0, en_lk = 1'b0, hs_hi = 1'b1;
  logic keys = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic hs, grn, vs, sep, lk, coast;
  logic irq, act_if, seek, hs_src, vs_src, pll_hs, sel_vs;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  vsd_src_model src (.clk(clk), .en_hs(en_hs), .en_grn(en_grn), .en_vs(en_vs),
    .en_lk(en_lk), .hs_hi(hs_hi), .hs(hs), .grn(grn), .vs(vs), .sep(sep), .lk(lk),
    .coast(coast));

  // short windows keep each settle near two hundred cycles
  vsd_top #(.HS_WIN(16), .VS_WIN(64), .LK_WIN(4)) uut (.CLK(clk), .RST(rst),
    .HSYNC_IN(hs), .GREEN_SYNC_IN(grn), .VSYNC_IN(vs), .SEP_VSYNC_IN(sep),
    .LINK_CLK_IN(lk), .COAST_IN(coast), .KEYS_LOADED_IN(keys), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .ACTIVE_IF(act_if),
    .SEEK_MODE(seek), .HS_SRC(hs_src), .VS_SRC(vs_src), .PLL_HSYNC(pll_hs),
    .SEL_VSYNC(sel_vs));

  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // long enough for any flag to rise or time out
  task automatic settle;
    repeat (200) @(posedge clk);
    @(negedge clk);
  endtask

  // selected syncs trail the chosen input by one cycle
  task automatic pass_chk;
    logic e1, e2;
    repeat (12) begin
      @(negedge clk);
      e1 = hs_src ? grn : hs;
      e2 = vs_src ? sep : vs;
      @(negedge clk);
      chk("pll_hs", {7'h00, pll_hs}, {7'h00, e1});
      chk("sel_vs", {7'h00, sel_vs}, {7'h00, e2});
    end
  endtask

  task automatic t_reset;
    chk("seek", {7'h00, seek}, 8'h01);
    rd_reg(CFG_COAST_ADDR, v);
    chk("coast cfg", v, CFG_COAST_RST);
    rd_reg(ACT_STAT_ADDR, v);
    chk("act idle", v, 8'h00);
    rd_reg(8'h30, v);
    chk("unmapped", v, 8'h00);
    rd_reg(IRQ_CLR_ADDR, v);
    chk("clr read", v, 8'h00);
  endtask

  task automatic t_iface;
    en_lk <= 1'b1;
    settle;
    rd_reg(ACT_STAT_ADDR, v);
    chk("digital only", v, 8'h18);
    chk("if digital", {6'h00, seek, act_if}, 8'h01);
    en_hs <= 1'b1;
    settle;
    rd_reg(ACT_STAT_ADDR, v);
    chk("both prio0", v, 8'h90);
    wr_reg(CFG_IF_ADDR, 8'h02);
    settle;
    chk("both prio1", {7'h00, act_if}, 8'h01);
    en_lk <= 1'b0;
    wr_reg(CFG_IF_ADDR, 8'h06);
    settle;
    chk("override", {6'h00, seek, act_if}, 8'h01);
    wr_reg(CFG_IF_ADDR, 8'h00);
    settle;
    wr_reg(ACT_STAT_ADDR, 8'hff);
    rd_reg(ACT_STAT_ADDR, v);
    chk("analog only", v, 8'h80);
    en_hs <= 1'b0;
    settle;
    rd_reg(ACT_STAT_ADDR, v);
    chk("steady hs", v, 8'h00);
    chk("seek again", {7'h00, seek}, 8'h01);
  endtask

  task automatic t_hsrc;
    logic [7:0] cfg [4] = '{8'h00, 8'h08, 8'h00, 8'h18};
    logic [3:0] hs_on = 4'b1101;
    logic [3:0] grn_on = 4'b0110;
    logic [3:0] exp = 4'b1010;
    logic [7:0] act_exp [4] = '{8'h80, 8'h40, 8'hc0, 8'h80};
    for (int i = 0; i < 4; i++) begin
      en_hs <= hs_on[i];
      en_grn <= grn_on[i];
      wr_reg(CFG_SYNC_ADDR, cfg[i]);
      settle;
      chk("hs_src", {7'h00, hs_src}, {7'h00, exp[i]});
      rd_reg(ACT_STAT_ADDR, v);
      chk("act flags", v, act_exp[i]);
      pass_chk;
    end
    en_grn <= 1'b0;
    en_vs <= 1'b1;
    wr_reg(CFG_SYNC_ADDR, 8'h00);
    settle;
    rd_reg(SRC_STAT_ADDR, v);
    chk("vs follow", v & 8'h20, 8'h20);
    wr_reg(CFG_SYNC_ADDR, 8'h02);
    settle;
    chk("vs ovr0", {7'h00, vs_src}, 8'h00);
    pass_chk;
    wr_reg(CFG_SYNC_ADDR, 8'h03);
    settle;
    chk("vs ovr1", {7'h00, vs_src}, 8'h01);
    wr_reg(CFG_SYNC_ADDR, 8'h00);
  endtask

  task automatic t_pol;
    keys <= 1'b1;
    settle;
    rd_reg(SRC_STAT_ADDR, v);
    chk("pol high", v & 8'h5c, 8'h5c);
    hs_hi <= 1'b0;
    wr_reg(CFG_COAST_ADDR, 8'h02);
    keys <= 1'b0;
    settle;
    rd_reg(SRC_STAT_ADDR, v);
    chk("pol low", v & 8'h5c, 8'h10);
    wr_reg(CFG_COAST_ADDR, CFG_COAST_RST);
    en_hs <= 1'b0;
    en_vs <= 1'b0;
    hs_hi <= 1'b1;
    settle;
  endtask

  task automatic t_irq;
    wr_reg(IRQ_CLR_ADDR, 8'h1f);
    rd_reg(IRQ_STAT_ADDR, v);
    chk("irq clean", v & 8'h04, 8'h00);
    wr_reg(IRQ_EN_ADDR, 8'h04);
    en_vs <= 1'b1;
    settle;
    rd_reg(IRQ_STAT_ADDR, v);
    chk("irq set", v & 8'h04, 8'h04);
    chk("irq out", {7'h00, irq}, 8'h01);
    wr_reg(IRQ_EN_ADDR, 8'h00);
    repeat (3) @(negedge clk);
    chk("irq mask", {7'h00, irq}, 8'h00);
    wr_reg(IRQ_CLR_ADDR, 8'h04);
    wr_reg(IRQ_EN_ADDR, 8'h04);
    repeat (3) @(negedge clk);
    chk("irq clr", {7'h00, irq}, 8'h00);
    en_vs <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset;
    t_iface;
    t_hsrc;
    t_pol;
    t_irq;
    results;
  end
endmodule
